// ===== bench/wdt_top_monitor.sv
// concurrent checks on the watchdog register bus and request outputs
`timescale 1ns/1ns
module wdt_top_monitor
  import wdt_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [15:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  input wire logic NMI_REQ,
  input wire logic RESET_REQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic done_rd;
  assign done_rd = READ && !WAITREQUEST;
  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  property p_take;
    (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST;
  endproperty
  a_take: assert property (p_take) else $error("access not answered after one wait");
  property p_wait_pulse;
    !WAITREQUEST |=> WAITREQUEST;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
  property p_rest;
    !READ && !WRITE |=> WAITREQUEST;
  endproperty
  a_rest: assert property (p_rest) else $error("waitrequest low while idle");
  // ----------------------------------------------------------------
  // read values
  // ----------------------------------------------------------------
  property p_ctl_bits;
    done_rd && ADDRESS == {IDX_CONTROL, 2'h0} |-> READDATA[31:6] == 26'h2;
  endproperty
  a_ctl_bits: assert property (p_ctl_bits) else $error("control fixed bits wrong");
  property p_stat_top;
    done_rd && ADDRESS == {IDX_STATUS, 2'h0} |-> READDATA[31:3] == {24'h0, STAT_TOP_BITS};
  endproperty
  a_stat_top: assert property (p_stat_top) else $error("status upper bits wrong");
  property p_code_zero;
    done_rd && ADDRESS == {IDX_CODE, 2'h0} |-> READDATA == READ_ZERO;
  endproperty
  a_code_zero: assert property (p_code_zero) else $error("code port read not zero");
  property p_misaligned;
    done_rd && ADDRESS[1:0] != 2'h0 |-> READDATA == READ_ZERO;
  endproperty
  a_misaligned: assert property (p_misaligned) else $error("misaligned read not zero");
  // ----------------------------------------------------------------
  // request outputs
  // ----------------------------------------------------------------
  property p_nmi_pulse;
    NMI_REQ |=> !NMI_REQ;
  endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("interrupt request not a pulse");
  property p_one_kind;
    RESET_REQ |-> !NMI_REQ ##1 !RESET_REQ;
  endproperty
  a_one_kind: assert property (p_one_kind) else $error("both request kinds at once");
endmodule
bind wdt_top wdt_top_monitor wdt_top_monitor_i (.CLK(CLK), .RST_N(RST_N), .ADDRESS(ADDRESS),
  .READ(READ), .WRITE(WRITE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
  .NMI_REQ(NMI_REQ), .RESET_REQ(RESET_REQ));

// ===== bench/wdt_top_tb.sv
// self-checking bench of the windowed watchdog
`timescale 1ns/1ns
module wdt_top_tb;
  import wdt_pkg::*;
  localparam int GT = 2;
  localparam logic [15:0] A_CTL = {IDX_CONTROL, 2'h0};
  localparam logic [15:0] A_CODE = {IDX_CODE, 2'h0};
  localparam logic [15:0] A_CNT = {IDX_COUNT, 2'h0};
  localparam logic [15:0] A_STAT = {IDX_STATUS, 2'h0};
  localparam logic [15:0] A_CFG = {IDX_CONFIG, 2'h0};
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [15:0] ADDRESS = 16'h0000;
  logic READ = 1'b0;
  logic WRITE = 1'b0;
  logic [31:0] WRITEDATA = 32'h0000_0000;
  logic [3:0] BYTEENABLE = 4'hF;
  logic LOW_CLK_PIN = 1'b0;
  logic SLOW_MODE = 1'b0;
  logic PAUSE = 1'b0;
  logic WARMUP_DONE = 1'b0;
  logic low_run = 1'b0;
  logic [3:0] lc = 4'h0;
  logic [31:0] READDATA;
  logic WAITREQUEST;
  logic NMI_REQ;
  logic RESET_REQ;
  logic [31:0] seed = 32'h0000_004C;
  logic [31:0] rd;
  logic [31:0] prev;
  logic [7:0] v;
  int errors = 0;
  int num_checks = 0;
  int n;

  always #25 CLK = ~CLK;
  // slow pin made in the bench domain; the design resynchronises it anyway
  always @(posedge CLK) begin
    lc <= lc + 4'h1;
    LOW_CLK_PIN <= low_run & lc[3];
  end

  wdt_top #(.GEAR_TICK_LOG2_P(GT), .LOW_TICK_LOG2_P(1)) wdt_top_i (.CLK(CLK), .RST_N(RST_N),
    .CE(1'b1), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .BYTEENABLE(BYTEENABLE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
    .LOW_CLK_PIN(LOW_CLK_PIN), .SLOW_MODE(SLOW_MODE), .PAUSE(PAUSE),
    .WARMUP_DONE(WARMUP_DONE), .NMI_REQ(NMI_REQ), .RESET_REQ(RESET_REQ));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [31:0] ctl_exp(input logic [7:0] w);
    return {24'h0, 2'h2, w[5:0]};
  endfunction
  function automatic int ovf(input int t);
    return 256 << (GT + 2 * t);
  endfunction

  task end_of_test;
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int k;
    @(posedge CLK);
    ADDRESS <= a;
    WRITEDATA <= {24'h0, d};
    READ <= ~wr;
    WRITE <= wr;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (WAITREQUEST !== 1'b0 && k < 20);
    if (k >= 20) begin
      errors++;
      end_of_test();
    end
    rd = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
  endtask

  task rdchk(input logic [15:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    check(rd, exp);
  endtask

  // leaving the running state needs enable cleared before the disable code
  task reconfig(input logic [7:0] w);
    bus(1'b1, A_CTL, 8'h00);
    bus(1'b1, A_CODE, CODE_DISABLE);
    bus(1'b1, A_CTL, w);
  endtask

  task wait_req(output int c);
    c = 0;
    while (NMI_REQ !== 1'b1 && RESET_REQ !== 1'b1 && c < 5000) begin
      @(posedge CLK);
      c++;
    end
  endtask

  initial begin
    #1000000;
    errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    rdchk(A_CTL, 32'hA6);
    rdchk(A_STAT, 32'h59);
    rdchk(A_CNT, 32'h00);
    bus(1'b0, A_CODE, 8'h00);
    bus(1'b0, A_CODE + 16'h1, 8'h00);
    bus(1'b1, A_CTL, 8'h39);
    BYTEENABLE <= 4'h0;
    bus(1'b1, A_CTL, 8'h00);
    BYTEENABLE <= 4'hF;
    rdchk(A_CTL, 32'hA6);
    bus(1'b1, A_CTL, 8'h00);
    rdchk(A_CTL, 32'h86);
    rdchk(A_STAT, 32'h59);
    bus(1'b1, A_CODE, CODE_DISABLE);
    rdchk(A_STAT, 32'h58);
    repeat (4) begin
      seed = xs(seed);
      v = {3'h1, seed[4:0]};
      reconfig(v);
      rdchk(A_CTL, ctl_exp(v));
      rdchk(A_STAT, 32'h59);
    end
    WARMUP_DONE <= 1'b1;
    reconfig(8'h20);
    wait_req(n);
    check(n > ovf(0) - 16 && n < ovf(0) + 16, 1);
    rdchk(A_STAT, 32'h5D);
    rdchk(A_STAT, 32'h59);
    repeat (100) @(posedge CLK);
    bus(1'b0, A_CNT, 8'h00);
    check(rd > 32'h14 && rd < 32'h28, 1);
    bus(1'b1, A_CODE, CODE_CLEAR);
    bus(1'b0, A_CNT, 8'h00);
    check(rd < 32'h3, 1);
    repeat (60) @(posedge CLK);
    seed = xs(seed);
    bus(1'b1, A_CODE, {seed[7:2], 2'h3});
    bus(1'b0, A_CNT, 8'h00);
    check(rd > 32'h0C, 1);
    reconfig(8'h30);
    repeat (100) @(posedge CLK);
    bus(1'b1, A_CODE, CODE_CLEAR);
    wait_req(n);
    check(n < 10, 1);
    rdchk(A_STAT, 32'h5B);
    bus(1'b0, A_CNT, 8'h00);
    check(rd > 32'h14, 1);
    n = 0;
    do begin
      bus(1'b0, A_CNT, 8'h00);
      n++;
    end while (rd[7:6] < 2'h2 && n < 300);
    bus(1'b1, A_CODE, CODE_CLEAR);
    bus(1'b0, A_CNT, 8'h00);
    check(rd < 32'h3, 1);
    rdchk(A_STAT, 32'h59);
    PAUSE <= 1'b1;
    bus(1'b0, A_CNT, 8'h00);
    prev = rd;
    repeat (50) @(posedge CLK);
    rdchk(A_CNT, prev);
    PAUSE <= 1'b0;
    repeat (20) @(posedge CLK);
    bus(1'b0, A_CNT, 8'h00);
    check(rd > prev, 1);
    reconfig(8'h21);
    wait_req(n);
    check({NMI_REQ, RESET_REQ}, 2'h1);
    check(n > ovf(0) - 16 && n < ovf(0) + 16, 1);
    // low clock through the divider select; gear counting would run far ahead
    reconfig(8'h20);
    bus(1'b1, A_CFG, 8'h01);
    rdchk(A_CFG, 32'h01);
    low_run <= 1'b1;
    bus(1'b0, A_CNT, 8'h00);
    prev = rd;
    repeat (400) @(posedge CLK);
    bus(1'b0, A_CNT, 8'h00);
    check(rd > prev + 4 && rd < prev + 32'h18, 1);
    end_of_test();
  end
endmodule

// ===== hw/wdt_pkg.sv
// constants and register map of the windowed watchdog
//
// Contract
// - overflow-time code picks 2^18..2^24 gear periods or 2^11..2^17 low-clock periods
// - overflow raises interrupt or reset request per action select; window violation always an interrupt request
// - while enabled, writes to window, time and action fields are ignored
// - fields written together with the write that sets enable are accepted
// - control bit 7 reads 1 and bit 6 reads 0
// - clear code written to the code port zeroes the counter, counting continues
// - disable code stops and zeroes only while enable is 0; other codes do nothing
// - count monitor returns the current 8-bit counter value
// - operating-state bit reads 1 while running, 0 while disabled
// - overflow-cause flag sets when overflow produces an interrupt request
// - window-violation flag sets when an early clear produces an interrupt request
// - reading status clears both cause flags
// - status bits 7 to 3 read their reset values
// - setting enable starts counting; no control code needed to re-enable
// - enable returns to 1 once warm-up after any reset completes
// - disable code beats a simultaneous overflow; overflow detection suppressed
// - first overflow after enable may come up to one source period early
// - window code 00 accepts a clear any time before overflow
// - nonzero window: early clear raises interrupt, counter keeps counting uncleared
// - with interrupt action, counter keeps counting after overflow
// - counter pauses in stop, warm-up, idle and sleep, resumes afterwards
// - window codes 01, 10, 11 open after a quarter, half, three quarters
// - action 1 gives a reset request, action 0 a non-maskable interrupt request
// - accepted clear beats a simultaneous overflow; no overflow detection
// - flag set coinciding with a status read stays set
package wdt_pkg;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_CONTROL = 14'hFD4;
  localparam logic [13:0] IDX_CODE = 14'hFD5;
  localparam logic [13:0] IDX_COUNT = 14'hFD6;
  localparam logic [13:0] IDX_STATUS = 14'hFD7;
  localparam logic [13:0] IDX_CONFIG = 14'hFD8;

  // ----------------------------------------------------------------
  // control register fields and reset values
  // ----------------------------------------------------------------
  localparam int CTL_EN_BIT = 5;
  localparam int CTL_WIN_LSB = 3;
  localparam int CTL_TIME_LSB = 1;
  localparam int CTL_ACT_BIT = 0;
  localparam logic [1:0] CTL_TOP_BITS = 2'h2;
  localparam logic RST_EN = 1'b1;
  localparam logic [1:0] RST_WIN = 2'h0;
  localparam logic [1:0] RST_TIME = 2'h3;
  localparam logic RST_ACT = 1'b0;
  localparam logic RST_DIV_SEL = 1'b0;
  localparam int CFG_DIV_BIT = 0;

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  localparam logic [4:0] STAT_TOP_BITS = 5'h0B;
  localparam int STAT_OVF_BIT = 2;
  localparam int STAT_WIN_BIT = 1;

  // ----------------------------------------------------------------
  // control codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_CLEAR = 8'h4E;
  localparam logic [7:0] CODE_DISABLE = 8'hB1;

  // ----------------------------------------------------------------
  // timing: log2 of source periods per counter tick (period / 256)
  // ----------------------------------------------------------------
  localparam int GEAR_PERIOD_LOG2 = 18;
  localparam int LOW_PERIOD_LOG2 = 11;
  localparam int COUNT_LOG2 = 8;
  localparam int LOW_TICK_LOG2 = LOW_PERIOD_LOG2 - COUNT_LOG2;
  localparam int GEAR_TICK_LOG2 = GEAR_PERIOD_LOG2 - COUNT_LOG2;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage

// ===== hw/wdt_prescaler.sv
// divides source pulses down to one counter tick per 2^shift pulses
`timescale 1ns/1ns
module wdt_prescaler #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  wdt_tick_if.scaler tk
);
  logic [WIDTH-1:0] pcnt;
  logic [WIDTH-1:0] limit;

  assign limit = WIDTH'((64'(1) << tk.shift) - 64'(1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pcnt <= '0;
      tk.tick <= 1'b0;
    end else if (ce) begin
      tk.tick <= 1'b0;
      if (tk.clr) begin
        pcnt <= '0;
      end else if (tk.src_pulse) begin
        if (pcnt >= limit) begin
          pcnt <= '0;
          tk.tick <= 1'b1;
        end else begin
          pcnt <= pcnt + WIDTH'(1);
        end
      end
    end
  end
endmodule

// ===== hw/wdt_sync.sv
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ns
module wdt_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic async_in,
  output logic rise
);
  logic s1;
  logic s2;
  logic s3;
  logic level;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else if (ce) begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b0;
      rise <= 1'b0;
    end else if (ce) begin
      rise <= 1'b0;
      if (s2 == s3 && s3 != level) begin
        level <= s3;
        rise <= s3;
      end
    end
  end
endmodule

// ===== hw/wdt_tick_if.sv
// tick request and answer between the watchdog core and its prescaler
`timescale 1ns/1ns
interface wdt_tick_if;
  logic src_pulse;
  logic [4:0] shift;
  logic clr;
  logic tick;

  modport core (output src_pulse, output shift, output clr, input tick);
  modport scaler (input src_pulse, input shift, input clr, output tick);
endinterface

// ===== hw/wdt_top.sv
// windowed watchdog core with Avalon-MM register slave
`timescale 1ns/1ns
module wdt_top
  import wdt_pkg::*;
#(
  parameter int GEAR_TICK_LOG2_P = GEAR_TICK_LOG2,
  parameter int LOW_TICK_LOG2_P = LOW_TICK_LOG2
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [15:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic LOW_CLK_PIN,
  input wire logic SLOW_MODE,
  input wire logic PAUSE,
  input wire logic WARMUP_DONE,
  output logic NMI_REQ,
  output logic RESET_REQ
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic en;
  logic [1:0] win;
  logic [1:0] otime;
  logic act;
  logic div_sel;
  logic running;
  logic [7:0] cnt;
  logic ovf_flag;
  logic win_flag;
  logic [1:0] reported;
  logic low_rise;

  logic [13:0] idx;
  logic hit;
  logic do_wr;
  logic do_rd;
  logic [7:0] wd;
  logic code_wr;
  logic clr_code;
  logic dis_code;
  logic active;
  logic in_window;
  logic clr_ok;
  logic clr_bad;
  logic dis_ok;
  logic ovf_raw;
  logic ovf;
  logic start;
  logic use_low;
  logic [7:0] ctl_rd;
  logic [7:0] stat_rd;
  logic [7:0] next_rd;

  wdt_tick_if tk ();

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign idx = ADDRESS[15:2];
  assign hit = ADDRESS[1:0] == 2'h0;
  assign do_wr = WRITE && !WAITREQUEST && hit && BYTEENABLE[0];
  assign do_rd = READ && !WAITREQUEST && hit;
  assign wd = WRITEDATA[7:0];
  // partial writes are not a meaningful code, only whole values count
  assign code_wr = do_wr && idx == IDX_CODE;
  assign clr_code = code_wr && wd == CODE_CLEAR;
  assign dis_code = code_wr && wd == CODE_DISABLE;

  // ----------------------------------------------------------------
  // counting conditions
  // ----------------------------------------------------------------
  assign active = running && WARMUP_DONE && !PAUSE;
  assign use_low = SLOW_MODE || div_sel;

  // window opens after 0, 1/4, 1/2 or 3/4 of the period
  assign in_window = (win == 2'h0) || (cnt[7:6] >= win);
  assign dis_ok = dis_code && !en;
  assign clr_ok = clr_code && running && in_window && !dis_ok;
  assign clr_bad = clr_code && running && !in_window && !dis_ok;
  assign ovf_raw = active && tk.tick && cnt == 8'hFF;
  // clear and disable both win over a coincident overflow
  assign ovf = ovf_raw && !clr_ok && !dis_ok;
  assign start = do_wr && idx == IDX_CONTROL && wd[CTL_EN_BIT] && !running;

  // ----------------------------------------------------------------
  // prescaler hookup
  // ----------------------------------------------------------------
  // the low clock edge is free-running against enable, so the first
  // tick after start may come up to one source period early
  assign tk.src_pulse = active && (use_low ? low_rise : 1'b1);
  assign tk.shift = 5'(2 * int'(otime) + (use_low ? LOW_TICK_LOG2_P : GEAR_TICK_LOG2_P));
  assign tk.clr = clr_ok || dis_ok || start || !running;

  wdt_sync u_low_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .async_in(LOW_CLK_PIN),
    .rise(low_rise)
  );

  wdt_prescaler #(.WIDTH(16)) u_prescaler (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .tk(tk.scaler)
  );

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, then the access completes
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WAITREQUEST <= 1'b1;
    end else if (CE) begin
      if ((READ || WRITE) && WAITREQUEST) begin
        WAITREQUEST <= 1'b0;
      end else begin
        WAITREQUEST <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      en <= RST_EN;
      win <= RST_WIN;
      otime <= RST_TIME;
      act <= RST_ACT;
    end else if (CE) begin
      if (do_wr && idx == IDX_CONTROL) begin
        en <= wd[CTL_EN_BIT];
        // fields only move while disabled; the enabling write itself sees en low
        if (!en) begin
          win <= wd[CTL_WIN_LSB +: 2];
          otime <= wd[CTL_TIME_LSB +: 2];
          act <= wd[CTL_ACT_BIT];
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_sel <= RST_DIV_SEL;
    end else if (CE) begin
      if (do_wr && idx == IDX_CONFIG) begin
        div_sel <= wd[CFG_DIV_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // operating state
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      running <= 1'b1;
    end else if (CE) begin
      if (dis_ok) begin
        running <= 1'b0;
      end else if (start) begin
        running <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // 8-bit up counter
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt <= 8'h00;
    end else if (CE) begin
      if (dis_ok || clr_ok || start) begin
        cnt <= 8'h00;
      end else if (active && tk.tick) begin
        // wraps and keeps going after overflow
        cnt <= cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // requests
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      NMI_REQ <= 1'b0;
      RESET_REQ <= 1'b0;
    end else if (CE) begin
      NMI_REQ <= (ovf && !act) || clr_bad;
      RESET_REQ <= ovf && act;
    end
  end

  // ----------------------------------------------------------------
  // cause flags: clear only what the read reported, set wins
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ovf_flag <= 1'b0;
      win_flag <= 1'b0;
    end else if (CE) begin
      // a flag that rose after the read captured it survives that read
      ovf_flag <= (ovf && !act) || (ovf_flag && !(do_rd && idx == IDX_STATUS && reported[1]));
      win_flag <= clr_bad || (win_flag && !(do_rd && idx == IDX_STATUS && reported[0]));
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in the wait cycle
  // ----------------------------------------------------------------
  assign ctl_rd = {CTL_TOP_BITS, en, win, otime, act};
  assign stat_rd = {STAT_TOP_BITS, ovf_flag, win_flag, running};

  always_comb begin
    next_rd = 8'h00;
    if (hit) begin
      case (idx)
        IDX_CONTROL: next_rd = ctl_rd;
        IDX_COUNT: next_rd = cnt;
        IDX_STATUS: next_rd = stat_rd;
        IDX_CONFIG: next_rd = {7'h00, div_sel};
        default: next_rd = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      READDATA <= READ_ZERO;
      reported <= 2'h0;
    end else if (CE) begin
      if (READ && WAITREQUEST) begin
        READDATA <= {24'h000000, next_rd};
        reported <= {ovf_flag, win_flag};
      end
    end
  end

endmodule
